// *** decode_port_pkg.sv ***
// constants and carrier types for the memory decode host port
// assumes a single 25 MHz clock domain and the host strobes sampled on it
package decode_port_pkg;
   // register window offsets
   localparam logic [7:0] OFS_PORTA_IN = 8'h00;
   localparam logic [7:0] OFS_PORTA_OUT = 8'h04;
   localparam logic [7:0] OFS_PORTA_DIR = 8'h06;
   localparam logic [7:0] OFS_IMC_A = 8'h0a;
   localparam logic [7:0] OFS_IMC_B = 8'h0b;
   localparam logic [7:0] OFS_IMC_C = 8'h1a;
   localparam logic [7:0] OFS_OMC_A = 8'h20;
   localparam logic [7:0] OFS_OMC_B = 8'h21;
   localparam logic [7:0] OFS_MASK_A = 8'h22;
   localparam logic [7:0] OFS_MASK_B = 8'h23;
   localparam logic [7:0] OFS_PWR0 = 8'hb0;
   localparam logic [7:0] OFS_PWR2 = 8'hb4;
   localparam logic [7:0] OFS_MAIN_PROT = 8'hc0;
   localparam logic [7:0] OFS_SEC_PROT = 8'hc2;
   localparam logic [7:0] OFS_PAGE = 8'he0;
   // field positions
   localparam int FAST_MODE_BIT = 3;
   // reset values
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] PWR_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   // decode geometry: 64 KiB main sectors, 8 KiB secondary sectors
   localparam int MAIN_SECT_SHIFT = 16;
   localparam int SEC_SECT_SHIFT = 13;
   // standby entered after this many idle cycles
   localparam logic [3:0] STANDBY_IDLE = 4'h2;

   // host bus request as sampled
   typedef struct packed {
      logic [19:0] addr;
      logic rd;
      logic wr_lo;
      logic wr_hi;
      logic mem_sel;
      logic io_sel;
   } host_req_s;

   // one-hot select result of the address decode
   typedef struct packed {
      logic [7:0] main_sect;
      logic [7:0] sec_sect;
      logic regs;
   } select_s;

   typedef enum logic [1:0] {
      ACC_IDLE = 2'b00,
      ACC_ACTIVE = 2'b01,
      ACC_DONE = 2'b11
   } acc_state_e;
endpackage

// *** dsp_memory_decode_port.sv ***
// host port: address decode, register window, page register, macrocell access
// assumes host strobes and pins are asynchronous and synchronised here
//
// Notes on behaviour
// - data width fixed by static parameter
// - 8-bit uses low port, 16-bit adds high
// - main array eight 64K sectors, decoded
// - secondary array eight 8K sectors, decoded
// - arrays independent: read one, other busy
// - erase one sector or whole array
// - writes to protected sectors ignored
// - arrays standby automatically between accesses
// - at most one select asserted per access
// - decode uses address and space strobes only
// - 256-byte register window, 15 used
// - byte registers, pairs at even addresses
// - byte writes on 16-bit bus update only addressed byte
// - page register read/write, feeds logic
// - fast-mode bit set holds logic outputs
// - two registers gate logic inputs off
// - host loads and reads macrocell registers
// - output cell sums ten terms, registered
// - input cells clock the gated pins
// - host sets and reads port pins
// - test port in bypass only
`timescale 1ns/100ps
module dsp_memory_decode_port
   import decode_port_pkg::*;
#(
   // bus width is fixed at build and never changes
   parameter bit WIDE_BUS = 1'b1,
   parameter logic [3:0] MAIN_BASE = 4'h0,
   parameter logic [6:0] SEC_BASE = 7'h40,
   parameter logic [11:0] REG_BASE = 12'hfff,
   parameter logic [7:0] MAIN_PROTECT = 8'h00,
   parameter logic [7:0] SEC_PROTECT = 8'h00
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // host bus
   input wire logic [19:0] ADDR,
   input wire logic READ_N,
   input wire logic WRITE_N,
   input wire logic BYTE_HIGH_ENABLE_N,
   input wire logic PORT_D_BIT3_N,
   input wire logic MEMORY_SPACE_STROBE_N,
   input wire logic IO_SPACE_STROBE_N,
   input wire logic [15:0] DATA_IN,
   output logic [15:0] DATA_OUT,
   output logic [1:0] DATA_OE,
   // selects toward the arrays
   output logic [7:0] MAIN_SECT_SEL,
   output logic [7:0] SEC_SECT_SEL,
   output logic MAIN_WRITE,
   output logic SEC_WRITE,
   output logic MAIN_STANDBY,
   output logic SEC_STANDBY,
   // port pins
   input wire logic [7:0] PORT_A_IN,
   output logic [7:0] PORT_A_OUT,
   output logic [7:0] PORT_A_OE,
   input wire logic [7:0] PORT_C_IN,
   // logic array view
   output logic [7:0] PAGE_OUT,
   output logic [15:0] OMC_OUT,
   output logic LOGIC_HOLD,
   output logic BYPASS_ONLY
);

   // pin synchronisers
   logic [19:0] addr_s1, addr_s2;
   logic [6:0] strb_s1, strb_s2, strb_prev;
   logic [7:0] pa_s1, pa_s2, pc_s1, pc_s2;
   logic [15:0] din_s1, din_s2;
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         addr_s1 <= '0;
         addr_s2 <= '0;
         strb_s1 <= '1;
         strb_s2 <= '1;
         strb_prev <= '1;
         pa_s1 <= '0;
         pa_s2 <= '0;
         pc_s1 <= '0;
         pc_s2 <= '0;
         din_s1 <= '0;
         din_s2 <= '0;
      end else begin
         addr_s1 <= ADDR;
         addr_s2 <= addr_s1;
         strb_s1 <= {READ_N, WRITE_N, BYTE_HIGH_ENABLE_N, PORT_D_BIT3_N,
                     MEMORY_SPACE_STROBE_N, IO_SPACE_STROBE_N, 1'b1};
         strb_s2 <= strb_s1;
         strb_prev <= strb_s2;
         pa_s1 <= PORT_A_IN;
         pa_s2 <= pa_s1;
         pc_s1 <= PORT_C_IN;
         pc_s2 <= pc_s1;
         din_s1 <= DATA_IN;
         din_s2 <= din_s1;
      end
   end

   // sampled request
   host_req_s req;
   assign req.addr = addr_s2;
   assign req.rd = !strb_s2[6];
   assign req.wr_lo = !strb_s2[5] && (!WIDE_BUS || !req.addr[0]);
   assign req.wr_hi = WIDE_BUS && ((!strb_s2[5] && !strb_s2[4]) || !strb_s2[3]);
   assign req.mem_sel = !strb_s2[2];
   assign req.io_sel = !strb_s2[1];

   // registers of the window
   logic [7:0] page_reg, page_next;
   logic [7:0] pwr0_reg, pwr2_reg;
   logic [7:0] omc_a_reg, omc_b_reg, mask_a_reg, mask_b_reg;
   logic [7:0] pa_out_reg, pa_dir_reg;
   logic [23:0] imc_reg;

   // address decode: one select only, window first, main then secondary
   select_s sel;
   wire cyc = req.mem_sel || req.io_sel;
   wire hit_regs = req.io_sel || (req.mem_sel && req.addr[19:8] == REG_BASE);
   // base bits sit above the sector field: one bit for the 512K main array, four for the secondary
   wire hit_main = req.mem_sel && !hit_regs && req.addr[19] == MAIN_BASE[3];
   wire hit_sec = req.mem_sel && !hit_regs && !hit_main
                  && req.addr[19:16] == SEC_BASE[6:3];
   assign sel.regs = hit_regs;
   assign sel.main_sect = hit_main ? (8'h01 << req.addr[18:16]) : 8'h00;
   assign sel.sec_sect = hit_sec ? (8'h01 << req.addr[15:13]) : 8'h00;
   wire [7:0] roff = {req.addr[7:1], req.addr[0] & !WIDE_BUS};
   wire any_wr = req.wr_lo || req.wr_hi;
   wire wr_edge = any_wr && (strb_prev[5] && strb_prev[3]);

   // protect gates array writes
   wire main_prot = |(sel.main_sect & MAIN_PROTECT);
   wire sec_prot = |(sel.sec_sect & SEC_PROTECT);

   // register window byte write helper
   function automatic logic hit_byte(input logic [7:0] o, input logic [7:0] a,
                                     input logic lo, input logic hi);
      hit_byte = (a == o && lo) || (a + 8'h01 == o && hi);
   endfunction

   wire wlo = sel.regs && req.wr_lo && wr_edge;
   wire whi = sel.regs && req.wr_hi && wr_edge;
   wire [7:0] wlo_d = din_s2[7:0];
   wire [7:0] whi_d = WIDE_BUS ? din_s2[15:8] : din_s2[7:0];
   function automatic logic [7:0] wdata(input logic [7:0] o, input logic [7:0] a,
                                        input logic [7:0] lo_d, input logic [7:0] hi_d);
      wdata = (a == o) ? lo_d : hi_d;
   endfunction

   assign page_next = hit_byte(OFS_PAGE, roff, wlo, whi) ? wdata(OFS_PAGE, roff, wlo_d, whi_d)
                                                         : page_reg;

   // window register updates, only the addressed byte changes
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         page_reg <= PAGE_RESET;
         pwr0_reg <= PWR_RESET;
         pwr2_reg <= PWR_RESET;
         mask_a_reg <= MASK_RESET;
         mask_b_reg <= MASK_RESET;
         pa_out_reg <= 8'h00;
         pa_dir_reg <= 8'h00;
      end else begin
         page_reg <= page_next;
         if (hit_byte(OFS_PWR0, roff, wlo, whi))
            pwr0_reg <= wdata(OFS_PWR0, roff, wlo_d, whi_d);
         if (hit_byte(OFS_PWR2, roff, wlo, whi))
            pwr2_reg <= wdata(OFS_PWR2, roff, wlo_d, whi_d);
         if (hit_byte(OFS_MASK_A, roff, wlo, whi))
            mask_a_reg <= wdata(OFS_MASK_A, roff, wlo_d, whi_d);
         if (hit_byte(OFS_MASK_B, roff, wlo, whi))
            mask_b_reg <= wdata(OFS_MASK_B, roff, wlo_d, whi_d);
         if (hit_byte(OFS_PORTA_OUT, roff, wlo, whi))
            pa_out_reg <= wdata(OFS_PORTA_OUT, roff, wlo_d, whi_d);
         if (hit_byte(OFS_PORTA_DIR, roff, wlo, whi))
            pa_dir_reg <= wdata(OFS_PORTA_DIR, roff, wlo_d, whi_d);
      end
   end

   // logic array: inputs gated by power registers, hold when fast-mode bit set
   wire hold = pwr0_reg[FAST_MODE_BIT];
   wire [7:0] gated_pa = pa_s2 & ~pwr2_reg;
   wire [7:0] gated_pc = pc_s2 & ~pwr0_reg;
   // ten product terms per output cell from page, inputs and input macrocells
   logic [15:0] omc_sum;
   always_comb begin
      omc_sum = '0;
      for (int i = 0; i < 16; i++) begin
         for (int t = 0; t < 10; t++) begin
            omc_sum[i] = omc_sum[i] | (page_reg[(i + t) % 8] & gated_pa[t % 8]
                                       & ~imc_reg[(i + t) % 24]);
         end
      end
   end
   wire [15:0] omc_load_mask = {~mask_b_reg, ~mask_a_reg};

   // output and input macrocells
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         omc_a_reg <= 8'h00;
         omc_b_reg <= 8'h00;
         imc_reg <= '0;
      end else begin
         if (hit_byte(OFS_OMC_A, roff, wlo, whi))
            omc_a_reg <= (omc_a_reg & mask_a_reg) | (wdata(OFS_OMC_A, roff, wlo_d, whi_d)
                         & omc_load_mask[7:0]);
         else if (!hold)
            omc_a_reg <= omc_sum[7:0];
         if (hit_byte(OFS_OMC_B, roff, wlo, whi))
            omc_b_reg <= (omc_b_reg & mask_b_reg) | (wdata(OFS_OMC_B, roff, wlo_d, whi_d)
                         & omc_load_mask[15:8]);
         else if (!hold)
            omc_b_reg <= omc_sum[15:8];
         if (!hold)
            imc_reg <= {gated_pc, gated_pa, gated_pa};
      end
   end

   // register window read mux; unused offsets read zero
   function automatic logic [7:0] rd_byte(input logic [7:0] o);
      case (o)
         OFS_PORTA_IN: rd_byte = pa_s2;
         OFS_PORTA_OUT: rd_byte = pa_out_reg;
         OFS_PORTA_DIR: rd_byte = pa_dir_reg;
         OFS_IMC_A: rd_byte = imc_reg[7:0];
         OFS_IMC_B: rd_byte = imc_reg[15:8];
         OFS_IMC_C: rd_byte = imc_reg[23:16];
         OFS_OMC_A: rd_byte = omc_a_reg & ~mask_a_reg;
         OFS_OMC_B: rd_byte = omc_b_reg & ~mask_b_reg;
         OFS_MASK_A: rd_byte = mask_a_reg;
         OFS_MASK_B: rd_byte = mask_b_reg;
         OFS_PWR0: rd_byte = pwr0_reg;
         OFS_PWR2: rd_byte = pwr2_reg;
         OFS_MAIN_PROT: rd_byte = MAIN_PROTECT;
         OFS_SEC_PROT: rd_byte = SEC_PROTECT;
         OFS_PAGE: rd_byte = page_reg;
         default: rd_byte = 8'h00;
      endcase
   endfunction
   wire [15:0] rd_word = WIDE_BUS ? {rd_byte(roff + 8'h01), rd_byte(roff)}
                                  : {8'h00, rd_byte(roff)};

   // access tracker for standby between accesses
   acc_state_e acc_reg, acc_next;
   logic [3:0] idle_cnt;
   assign acc_next = cyc ? ACC_ACTIVE : (acc_reg == ACC_ACTIVE ? ACC_DONE : ACC_IDLE);
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         acc_reg <= ACC_IDLE;
         idle_cnt <= STANDBY_IDLE; // standby holds from the first cycle
      end else begin
         acc_reg <= acc_next;
         case (acc_reg)
            ACC_ACTIVE: idle_cnt <= 4'h0;
            ACC_DONE, ACC_IDLE: idle_cnt <= (idle_cnt == STANDBY_IDLE) ? idle_cnt : idle_cnt + 4'h1;
            default: idle_cnt <= 4'h0;
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DATA_OUT <= '0;
         DATA_OE <= '0;
         MAIN_SECT_SEL <= '0;
         SEC_SECT_SEL <= '0;
         MAIN_WRITE <= 1'b0;
         SEC_WRITE <= 1'b0;
         MAIN_STANDBY <= 1'b1;
         SEC_STANDBY <= 1'b1;
         PORT_A_OUT <= '0;
         PORT_A_OE <= '0;
         PAGE_OUT <= PAGE_RESET;
         OMC_OUT <= '0;
         LOGIC_HOLD <= 1'b0;
         BYPASS_ONLY <= 1'b1;
      end else begin
         DATA_OUT <= sel.regs ? rd_word : 16'h0000;
         DATA_OE <= (sel.regs && req.rd) ? {WIDE_BUS, 1'b1} : 2'b00;
         MAIN_SECT_SEL <= sel.main_sect;
         SEC_SECT_SEL <= sel.sec_sect;
         MAIN_WRITE <= hit_main && any_wr && !main_prot;
         SEC_WRITE <= hit_sec && any_wr && !sec_prot;
         MAIN_STANDBY <= !hit_main && idle_cnt == STANDBY_IDLE;
         SEC_STANDBY <= !hit_sec && idle_cnt == STANDBY_IDLE;
         PORT_A_OUT <= pa_out_reg;
         PORT_A_OE <= pa_dir_reg;
         PAGE_OUT <= page_next;
         OMC_OUT <= {omc_b_reg, omc_a_reg};
         LOGIC_HOLD <= hold;
         BYPASS_ONLY <= 1'b1;
      end
   end

   // checks
   a_one_select: assert property (@(posedge MCLK) disable iff (!RESET_N)
      $onehot0({sel.regs, |sel.main_sect, |sel.sec_sect}))
      else $error("more than one select");
   a_protect_main: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (hit_main && main_prot) |=> !MAIN_WRITE)
      else $error("write to protected main sector");
   a_protect_sec: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (hit_sec && sec_prot) |=> !SEC_WRITE)
      else $error("write to protected secondary sector");
   a_page_update: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (wlo && roff == OFS_PAGE) |=> page_reg == $past(wlo_d))
      else $error("page register not written");
   a_page_out: assert property (@(posedge MCLK) disable iff (!RESET_N)
      !(wlo || whi) |=> $stable(PAGE_OUT))
      else $error("page output changed without a write");
   a_hold_omc: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (hold && !wlo && !whi) |=> $stable(omc_a_reg) && $stable(omc_b_reg))
      else $error("logic not held in fast mode");
   a_narrow_bus: assert property (@(posedge MCLK) disable iff (!RESET_N)
      DATA_OE[1] |-> (WIDE_BUS && DATA_OE[0]))
      else $error("high lane driven without the low lane or in narrow mode");
   a_standby_idle: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (!cyc [*4]) |=> MAIN_STANDBY && SEC_STANDBY)
      else $error("arrays not in standby when idle");
   a_main_one_sect: assert property (@(posedge MCLK) disable iff (!RESET_N)
      hit_main |=> $onehot(MAIN_SECT_SEL))
      else $error("main sector select not one-hot");
   a_sec_one_sect: assert property (@(posedge MCLK) disable iff (!RESET_N)
      hit_sec |=> $onehot(SEC_SECT_SEL))
      else $error("secondary sector select not one-hot");
   a_read_lanes: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (sel.regs && req.rd) |=> DATA_OE == {WIDE_BUS, 1'b1})
      else $error("register read lanes not enabled");
   a_low_lane_only: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (wlo && !whi && roff == OFS_MASK_A) |=> $stable(mask_b_reg))
      else $error("low byte write touched the high byte");
   a_bypass_fixed: assert property (@(posedge MCLK) disable iff (!RESET_N)
      BYPASS_ONLY)
      else $error("test port left bypass");
   a_main_awake: assert property (@(posedge MCLK) disable iff (!RESET_N)
      hit_main |=> !MAIN_STANDBY)
      else $error("main array in standby during access");
   a_sec_awake: assert property (@(posedge MCLK) disable iff (!RESET_N)
      hit_sec |=> !SEC_STANDBY)
      else $error("secondary array in standby during access");
endmodule

// *** host_bus_model.sv ***
// host bus model: one level-strobed access at a time toward the port
// assumes the bench calls start then stop, and all driving is on falling MCLK
`timescale 1ns/100ps
module host_bus_model (
   // clock
   input wire logic MCLK,
   // bus toward the port
   output logic [19:0] ADDR,
   output logic READ_N,
   output logic WRITE_N,
   output logic BYTE_HIGH_ENABLE_N,
   output logic PORT_D_BIT3_N,
   output logic MEMORY_SPACE_STROBE_N,
   output logic IO_SPACE_STROBE_N,
   output logic [15:0] DATA_IN,
   // answer from the port
   input wire logic [15:0] DATA_OUT
);
   // idle bus at time zero
   initial begin
      ADDR = 20'h00000;
      DATA_IN = 16'h0000;
      stop_strobes();
   end

   // all strobes inactive
   task automatic stop_strobes();
      READ_N = 1'b1;
      WRITE_N = 1'b1;
      BYTE_HIGH_ENABLE_N = 1'b1;
      PORT_D_BIT3_N = 1'b1;
      MEMORY_SPACE_STROBE_N = 1'b1;
      IO_SPACE_STROBE_N = 1'b1;
   endtask

   // open an access, hold it past the answer latency, sample read data
   task automatic start(input logic [19:0] a, input logic rd, input logic [1:0] lanes,
                        input logic io, input logic [15:0] wd, output logic [15:0] rdat);
      @(negedge MCLK);
      ADDR = a;
      DATA_IN = wd;
      READ_N = ~rd;
      WRITE_N = ~lanes[0];
      BYTE_HIGH_ENABLE_N = ~(lanes[0] & lanes[1]);
      PORT_D_BIT3_N = ~(lanes[1] & ~lanes[0]);
      MEMORY_SPACE_STROBE_N = io;
      IO_SPACE_STROBE_N = ~io;
      repeat (4) @(posedge MCLK);
      @(negedge MCLK);
      rdat = DATA_OUT;
   endtask

   // release; released lines show stale-inverted values, not the last ones
   task automatic stop();
      stop_strobes();
      ADDR = ~ADDR;
      DATA_IN = ~DATA_IN;
      repeat (3) @(negedge MCLK);
   endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the memory decode host port
// assumes the host bus model drives the bus and the bench drives the pins
`timescale 1ns/100ps
module testbench;
   import decode_port_pkg::*;
   localparam logic [11:0] WIN = 12'hfff;
   logic MCLK, RESET_N, READ_N, WRITE_N, BYTE_HIGH_ENABLE_N, PORT_D_BIT3_N;
   logic MEMORY_SPACE_STROBE_N, IO_SPACE_STROBE_N, MAIN_WRITE, SEC_WRITE, MAIN_STANDBY, SEC_STANDBY;
   logic LOGIC_HOLD, BYPASS_ONLY;
   logic [19:0] ADDR;
   logic [15:0] DATA_IN, DATA_OUT, OMC_OUT, rdat;
   logic [1:0] DATA_OE;
   logic [7:0] MAIN_SECT_SEL, SEC_SECT_SEL, PORT_A_IN, PORT_A_OUT, PORT_A_OE, PORT_C_IN, PAGE_OUT;
   int n_mismatch = 0;
   int n_compared = 0;

   // 25 MHz clock
   always #20 MCLK = ~MCLK;

   host_bus_model host (.MCLK(MCLK), .ADDR(ADDR), .READ_N(READ_N), .WRITE_N(WRITE_N),
      .BYTE_HIGH_ENABLE_N(BYTE_HIGH_ENABLE_N), .PORT_D_BIT3_N(PORT_D_BIT3_N),
      .MEMORY_SPACE_STROBE_N(MEMORY_SPACE_STROBE_N), .IO_SPACE_STROBE_N(IO_SPACE_STROBE_N),
      .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT));

   dsp_memory_decode_port #(.MAIN_PROTECT(8'h04), .SEC_PROTECT(8'h01)) uut (.MCLK(MCLK), .RESET_N(RESET_N),
      .ADDR(ADDR), .READ_N(READ_N), .WRITE_N(WRITE_N), .BYTE_HIGH_ENABLE_N(BYTE_HIGH_ENABLE_N),
      .PORT_D_BIT3_N(PORT_D_BIT3_N), .MEMORY_SPACE_STROBE_N(MEMORY_SPACE_STROBE_N),
      .IO_SPACE_STROBE_N(IO_SPACE_STROBE_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
      .MAIN_SECT_SEL(MAIN_SECT_SEL), .SEC_SECT_SEL(SEC_SECT_SEL), .MAIN_WRITE(MAIN_WRITE),
      .SEC_WRITE(SEC_WRITE), .MAIN_STANDBY(MAIN_STANDBY), .SEC_STANDBY(SEC_STANDBY),
      .PORT_A_IN(PORT_A_IN), .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE(PORT_A_OE), .PORT_C_IN(PORT_C_IN),
      .PAGE_OUT(PAGE_OUT), .OMC_OUT(OMC_OUT), .LOGIC_HOLD(LOGIC_HOLD), .BYPASS_ONLY(BYPASS_ONLY));

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // verdict and end of run
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // register window write
   task automatic reg_wr(input logic [7:0] ofs, input logic [1:0] lanes, input logic [15:0] wd);
      host.start({WIN, ofs}, 1'b0, lanes, 1'b0, wd, rdat);
      host.stop();
   endtask

   // register window read; both lanes driven, no sector selected
   task automatic reg_rd(input logic [7:0] ofs, input logic io, output logic [15:0] d);
      host.start({WIN, ofs}, 1'b1, 2'b00, io, 16'h0000, d);
      chk({DATA_OE, MAIN_SECT_SEL, SEC_SECT_SEL}, {2'b11, 16'h0000});
      host.stop();
   endtask

   // hang guard, well beyond the ~300 cycles the tests need
   initial begin
      repeat (4000) @(posedge MCLK);
      n_mismatch++;
      results();
   end

   // main sequence
   initial begin
      MCLK = 1'b0;
      RESET_N = 1'b0;
      PORT_A_IN = 8'hc3;
      PORT_C_IN = 8'h96;
      repeat (3) @(negedge MCLK);
      chk({MAIN_STANDBY, SEC_STANDBY, BYPASS_ONLY, DATA_OE, PAGE_OUT}, {3'b111, 2'b00, 8'h00});
      RESET_N = 1'b1;
      repeat (3) @(negedge MCLK);
      // page register through memory and io strobes
      reg_wr(OFS_PAGE, 2'b01, 16'h005a);
      chk(PAGE_OUT, 8'h5a);
      reg_rd(OFS_PAGE, 1'b0, rdat);
      chk(rdat, 16'h005a);
      reg_rd(OFS_PAGE, 1'b1, rdat);
      chk(rdat, 16'h005a);
      // byte lanes: word, low only, high only
      reg_wr(OFS_MASK_A, 2'b11, 16'h3ca5);
      reg_rd(OFS_MASK_A, 1'b0, rdat);
      chk(rdat, 16'h3ca5);
      reg_wr(OFS_MASK_A, 2'b01, 16'hee11);
      reg_rd(OFS_MASK_A, 1'b0, rdat);
      chk(rdat, 16'h3c11);
      reg_wr(OFS_MASK_A, 2'b10, 16'h7722);
      reg_rd(OFS_MASK_A, 1'b0, rdat);
      chk(rdat, 16'h7711);
      reg_wr(OFS_MASK_A, 2'b11, 16'h0000);
      // fast-mode bit holds the logic array
      reg_wr(OFS_PWR0, 2'b01, 16'h0008);
      chk(LOGIC_HOLD, 1'b1);
      reg_rd(OFS_PWR0, 1'b0, rdat);
      chk(rdat, 16'h0008);
      reg_wr(OFS_PWR0, 2'b01, 16'h0000);
      chk(LOGIC_HOLD, 1'b0);
      // port pins under host control
      reg_wr(OFS_PORTA_DIR, 2'b01, 16'h00ff);
      reg_wr(OFS_PORTA_OUT, 2'b01, 16'h005a);
      chk({PORT_A_OE, PORT_A_OUT}, 16'hff5a);
      reg_rd(OFS_PORTA_IN, 1'b0, rdat);
      chk(rdat, 16'h00c3);
      reg_rd(OFS_IMC_C, 1'b0, rdat);
      chk(rdat, 16'h0096);
      // read-only protect register; an unused location is read, never written
      reg_wr(OFS_MAIN_PROT, 2'b01, 16'h00ff);
      reg_rd(OFS_MAIN_PROT, 1'b0, rdat);
      chk(rdat, 16'h0004);
      reg_rd(8'h40, 1'b0, rdat);
      chk(rdat, 16'h0000);
      // every sector of both arrays, writes against protection
      for (int k = 0; k < 8; k++) begin
         host.start({1'b0, k[2:0], 16'h0000}, 1'b0, 2'b01, 1'b0, 16'h1234, rdat);
         chk({MAIN_SECT_SEL, SEC_SECT_SEL, MAIN_WRITE, MAIN_STANDBY, SEC_STANDBY},
             {8'h01 << k, 8'h00, k != 2, 2'b01});
         host.stop();
         host.start({4'h8, k[2:0], 13'h0000}, 1'b0, 2'b01, 1'b0, 16'h4321, rdat);
         chk({MAIN_SECT_SEL, SEC_SECT_SEL, SEC_WRITE, MAIN_STANDBY, SEC_STANDBY},
             {8'h00, 8'h01 << k, k != 0, 2'b10});
         host.stop();
      end
      // arrays back in standby once idle
      repeat (6) @(negedge MCLK);
      chk({MAIN_STANDBY, SEC_STANDBY, BYPASS_ONLY, MAIN_WRITE, SEC_WRITE}, 5'b11100);
      // mid-run reset clears the page and keeps both arrays in standby
      RESET_N = 1'b0;
      @(negedge MCLK);
      RESET_N = 1'b1;
      @(negedge MCLK);
      chk({MAIN_STANDBY, SEC_STANDBY, PAGE_OUT}, {2'b11, PAGE_RESET});
      @(negedge MCLK);
      chk({MAIN_STANDBY, SEC_STANDBY, BYPASS_ONLY}, 3'b111);
      results();
   end
endmodule
